// ---- design/bit_sync.sv ----
// Two-stage synchroniser for levels and gray-coded pointers.
module bit_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_r;

    ////////////////////////////////////////////////////////////////////////////
    // The first stage feeds only the second stage.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end

endmodule : bit_sync

// ---- design/led_latch_pkg.sv ----
// Shared constants for the serial on/off latch block.
package led_latch_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Channel geometry.
    localparam int CHANNELS = 16;
    localparam int MSB_IDX = CHANNELS - 1;
    localparam int LSB_IDX = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Output levels.
    localparam logic [CHANNELS-1:0] CHANNELS_OFF = 16'h0000;
    localparam logic [CHANNELS-1:0] PRECHARGE_ALL_ON = 16'hffff;

    ////////////////////////////////////////////////////////////////////////////
    // Crossing buffer and synchroniser shape.
    localparam int FIFO_DEPTH = 16;
    localparam int SYNC_W = 2;
    localparam int SYNC_GATE_BIT = 0;
    localparam int SYNC_INHIBIT_BIT = 1;
    // Inhibit comes out of reset asserted so that nothing lights before the pin is seen.
    localparam logic [SYNC_W-1:0] SYNC_RESET_VAL = 2'h2;

    ////////////////////////////////////////////////////////////////////////////
    // Helper counter width for the shift fill tracker.
    localparam int FILL_W = 5;
    localparam logic [FILL_W-1:0] FILL_FULL = 5'h10;
    localparam logic [FILL_W-1:0] FILL_ONE = 5'h01;

endpackage : led_latch_pkg

// ---- design/serial_led_onoff_latch.sv ----
// Serial-in on/off shift register, level-gated latch and inhibited channel outputs.
//
// What this block does
// - Each rising shift clock edge moves the low fifteen shift bits one place toward the MSB; the old MSB drops out.
// - Each rising shift clock edge loads the serial input level into the shift LSB.
// - The cascade output is the shift register MSB and so changes on rising edges.
// - While the load gate is high the latch follows the shift register image last drained from the FIFO, else it holds.
// - With inhibit low a channel is on for a latch bit of one and off for zero.
// - With inhibit high every channel output is forced off.
// - The shift register and the latch have no reset and start undefined.
// - Shift register and latch are sixteen bits each, one per channel.
// - All pre-charge pull-ups are on while inhibit is high and off while it is low.
module serial_led_onoff_latch (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic shift_clk,
    input wire logic shift_data_in,
    input wire logic load_gate,
    input wire logic inhibit,
    input wire logic drain_hold,
    output logic cascade_data_out,
    output logic shift_ready,
    output logic [led_latch_pkg::CHANNELS-1:0] sink_channel,
    output logic [led_latch_pkg::CHANNELS-1:0] precharge_on
);
    import led_latch_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // Link domain: the shift register runs on the controller's own shift clock.

    logic [CHANNELS-1:0] shift_r;
    logic [CHANNELS-1:0] shift_nxt;
    logic [FILL_W-1:0] fill_r;
    logic [FILL_W-1:0] fill_nxt;

    always_comb begin
        shift_nxt = {shift_r[MSB_IDX-1:LSB_IDX], shift_data_in};
        fill_nxt = (fill_r == FILL_FULL) ? fill_r : fill_r + FILL_ONE;
    end

    // Only rising edges exist here, so a falling edge can change nothing.
    // No reset: contents are undefined until the controller shifts data in.
    always_ff @(posedge shift_clk) begin
        shift_r <= shift_nxt;
    end

    always_ff @(posedge shift_clk or negedge arst_n) begin
        if (!arst_n) begin
            fill_r <= '0;
        end else begin
            fill_r <= fill_nxt;
        end
    end

    // The cascade pin is the MSB flip-flop itself, with no extra stage.
    assign cascade_data_out = shift_r[MSB_IDX];

    ////////////////////////////////////////////////////////////////////////////
    // Crossing: every shift made while wr_ready is high pushes the new register image into the FIFO.
    // The image is pushed on the same edge that forms it, because the shift clock
    // may stop right after the last bit and no later edge can be counted on.

    logic fifo_valid;
    logic fifo_ready;
    logic [CHANNELS-1:0] fifo_word;

    word_fifo #(.WIDTH(CHANNELS), .DEPTH(FIFO_DEPTH)) u_fifo (
        .wr_clk(shift_clk),
        .rd_clk(ref_clk),
        .rst_n(arst_n),
        .wr_valid(1'b1),
        .wr_data(shift_nxt),
        .wr_ready(shift_ready),
        .rd_valid(fifo_valid),
        .rd_data(fifo_word),
        .rd_ready(fifo_ready)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers for the gate and the inhibit level.

    logic [SYNC_W-1:0] pins_s;
    logic gate_s;
    logic inhibit_s;

    bit_sync #(.WIDTH(SYNC_W), .RESET_VAL(SYNC_RESET_VAL)) u_pin_sync (
        .clk(ref_clk),
        .rst_n(arst_n),
        .async_in({inhibit, load_gate}),
        .sync_out(pins_s)
    );

    assign gate_s = pins_s[SYNC_GATE_BIT];
    assign inhibit_s = pins_s[SYNC_INHIBIT_BIT];

    ////////////////////////////////////////////////////////////////////////////
    // Latch: transparent while the gate is high, holding while it is low.
    // A held drain leaves the last image stale; the latch then shows older data.

    logic pop;
    logic [CHANNELS-1:0] last_word_r;
    logic [CHANNELS-1:0] last_word_nxt;
    logic [CHANNELS-1:0] latch_r;
    logic [CHANNELS-1:0] latch_nxt;

    always_comb begin
        fifo_ready = !drain_hold;
        pop = fifo_valid && fifo_ready;
        last_word_nxt = pop ? fifo_word : last_word_r;
        latch_nxt = gate_s ? last_word_nxt : latch_r;
    end

    // No reset on data: undefined until written.
    always_ff @(posedge ref_clk) begin
        last_word_r <= last_word_nxt;
        latch_r <= latch_nxt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Channel drive and pre-charge, one slice per channel.

    logic [CHANNELS-1:0] sink_nxt;
    logic [CHANNELS-1:0] precharge_nxt;

    // Continuous assignments keep each bit a single driver across the slices.
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        assign sink_nxt[ch] = latch_r[ch] && !inhibit_s;
        assign precharge_nxt[ch] = inhibit_s;
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sink_channel <= CHANNELS_OFF;
            precharge_on <= PRECHARGE_ALL_ON;
        end else begin
            sink_channel <= sink_nxt;
            precharge_on <= precharge_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Helper for checks: set once the latch has taken a word through the gate.

    logic loaded_r;
    logic loaded_nxt;

    always_comb begin
        loaded_nxt = loaded_r || (gate_s && pop);
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            loaded_r <= 1'b0;
        end else begin
            loaded_r <= loaded_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Link-domain checks. The move and cascade checks wait for sixteen shifts; the LSB check waits for one.

    a_shift_moves: assert property (
        @(posedge shift_clk) disable iff (!arst_n)
        (fill_r == FILL_FULL) |-> (shift_r[MSB_IDX:1] == $past(shift_r[MSB_IDX-1:LSB_IDX]))
    ) else $error("shift register did not move toward the MSB");

    a_lsb_loads: assert property (
        @(posedge shift_clk) disable iff (!arst_n)
        (fill_r != '0) |-> (shift_r[LSB_IDX] == $past(shift_data_in))
    ) else $error("shift LSB does not hold the sampled serial input");

    a_cascade_msb: assert property (
        @(posedge shift_clk) disable iff (!arst_n)
        (fill_r == FILL_FULL) |-> (cascade_data_out == $past(shift_r[MSB_IDX-1]))
    ) else $error("cascade output is not the shifted MSB");

    ////////////////////////////////////////////////////////////////////////////
    // Reference-domain checks.

    sequence s_gate_take;
        gate_s && pop;
    endsequence

    sequence s_gate_closed;
        loaded_r && !gate_s;
    endsequence

    a_gate_copies: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        s_gate_take |=> (latch_r == $past(fifo_word))
    ) else $error("latch did not copy the new word while the gate was high");

    a_gate_holds: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        s_gate_closed |=> $stable(latch_r)
    ) else $error("latch changed while the gate was low");

    a_channel_follows: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        (loaded_r && !inhibit_s) |=> (sink_channel == $past(latch_r))
    ) else $error("channel outputs do not follow the latch bits");

    a_inhibit_off: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        inhibit_s |=> (sink_channel == CHANNELS_OFF)
    ) else $error("a channel is on while inhibit is high");

    a_precharge_on: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        inhibit_s [*2] |=> (precharge_on == PRECHARGE_ALL_ON) && (sink_channel == CHANNELS_OFF)
    ) else $error("pre-charge not fully on under inhibit");

    a_precharge_off: assert property (
        @(posedge ref_clk) disable iff (!arst_n)
        !inhibit_s |=> (precharge_on == CHANNELS_OFF)
    ) else $error("pre-charge still on with inhibit low");

endmodule : serial_led_onoff_latch

// ---- design/word_fifo.sv ----
// Dual-clock word FIFO with gray pointers and a registered read stage.
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input wire logic wr_clk,
    input wire logic rd_clk,
    input wire logic rst_n,
    input wire logic wr_valid,
    input wire logic [WIDTH-1:0] wr_data,
    output logic wr_ready,
    output logic rd_valid,
    output logic [WIDTH-1:0] rd_data,
    input wire logic rd_ready
);

    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] PTR_ONE = {{AW{1'b0}}, 1'b1};

    function automatic logic [AW:0] bin2gray(input logic [AW:0] b);
        bin2gray = b ^ (b >> 1);
    endfunction : bin2gray

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin_r, wbin_nxt, wgray_r, wgray_nxt, rgray_q;
    logic [AW:0] rbin_r, rbin_nxt, rgray_r, rgray_nxt, wgray_q;
    logic wr_ready_nxt, wr_fire, rd_load, empty, rd_valid_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Write side.
    always_comb begin
        wr_fire = wr_valid && wr_ready;
        wbin_nxt = wr_fire ? wbin_r + PTR_ONE : wbin_r;
        wgray_nxt = bin2gray(wbin_nxt);
        wr_ready_nxt = wgray_nxt != {~rgray_q[AW:AW-1], rgray_q[AW-2:0]};
    end

    always_ff @(posedge wr_clk or negedge rst_n) begin
        if (!rst_n) begin
            wbin_r <= '0;
            wgray_r <= '0;
            wr_ready <= 1'b1;
        end else begin
            wbin_r <= wbin_nxt;
            wgray_r <= wgray_nxt;
            wr_ready <= wr_ready_nxt;
        end
    end

    always_ff @(posedge wr_clk) begin
        if (wr_fire) begin
            mem[wbin_r[AW-1:0]] <= wr_data;
        end
    end

    bit_sync #(.WIDTH(AW + 1), .RESET_VAL('0)) u_rptr_sync (
        .clk(wr_clk),
        .rst_n(rst_n),
        .async_in(rgray_r),
        .sync_out(rgray_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Read side.
    always_comb begin
        empty = rgray_r == wgray_q;
        rd_load = !empty && (!rd_valid || rd_ready);
        rbin_nxt = rd_load ? rbin_r + PTR_ONE : rbin_r;
        rgray_nxt = bin2gray(rbin_nxt);
        rd_valid_nxt = rd_load || (rd_valid && !rd_ready);
    end

    always_ff @(posedge rd_clk or negedge rst_n) begin
        if (!rst_n) begin
            rbin_r <= '0;
            rgray_r <= '0;
            rd_valid <= 1'b0;
        end else begin
            rbin_r <= rbin_nxt;
            rgray_r <= rgray_nxt;
            rd_valid <= rd_valid_nxt;
        end
    end

    always_ff @(posedge rd_clk) begin
        if (rd_load) begin
            rd_data <= mem[rbin_r[AW-1:0]];
        end
    end

    bit_sync #(.WIDTH(AW + 1), .RESET_VAL('0)) u_wptr_sync (
        .clk(rd_clk),
        .rst_n(rst_n),
        .async_in(wgray_r),
        .sync_out(wgray_q)
    );

endmodule : word_fifo

// ---- testbench/led_ctl_model.sv ----
// Behavioural display controller that clocks on/off words into the serial chain.
module led_ctl_model (
    output logic shift_clk,
    output logic shift_data_in
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        shift_clk = 1'b0;
        shift_data_in = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////
    // The clock stands still between frames; the data line is inverted afterwards so
    // that a design sampling it outside a frame cannot pass by luck.
    task automatic shift_bits(input logic [15:0] w, input int n);
        for (int i = n - 1; i >= 0; i--) begin
            shift_data_in = w[i];
            #43;
            shift_clk = 1'b1;
            #80;
            shift_clk = 1'b0;
            #37;
        end
        shift_data_in = ~shift_data_in;
    endtask : shift_bits

endmodule : led_ctl_model

// ---- testbench/tb.sv ----
// Self-checking bench for the serial on/off latch block.
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import led_latch_pkg::*;

    logic ref_clk = 1'b0;
    logic arst_n;
    logic load_gate;
    logic inhibit;
    logic drain_hold;
    logic shift_clk;
    logic shift_data_in;
    logic cascade_data_out;
    logic shift_ready;
    logic [CHANNELS-1:0] sink_channel;
    logic [CHANNELS-1:0] precharge_on;
    int n_mismatch = 0;
    int n_checks = 0;

    always #10 ref_clk = ~ref_clk;

    led_ctl_model u_ctl (.shift_clk(shift_clk), .shift_data_in(shift_data_in));

    serial_led_onoff_latch i_dut (
        .ref_clk(ref_clk), .arst_n(arst_n), .shift_clk(shift_clk),
        .shift_data_in(shift_data_in), .load_gate(load_gate), .inhibit(inhibit),
        .drain_hold(drain_hold), .cascade_data_out(cascade_data_out),
        .shift_ready(shift_ready), .sink_channel(sink_channel), .precharge_on(precharge_on)
    );

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic drive(input logic g, input logic inh, input logic hold);
        @(negedge ref_clk);
        load_gate = g;
        inhibit = inh;
        drain_hold = hold;
    endtask : drive

    // Bounded wait, since the crossing latency is a few reference cycles, not a fixed count.
    task automatic settle_sink(input logic [15:0] exp);
        for (int i = 0; i < 24 && sink_channel !== exp; i++) @(negedge ref_clk);
    endtask : settle_sink

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_load_show();
        drive(1'b0, 1'b1, 1'b0);
        u_ctl.shift_bits(16'ha5c3, 16);
        drive(1'b1, 1'b1, 1'b0);
        repeat (8) @(negedge ref_clk);
        chk("sink inhibited", sink_channel, 16'h0000);
        chk("precharge inhibited", precharge_on, 16'hffff);
        drive(1'b0, 1'b0, 1'b0);
        settle_sink(16'ha5c3);
        chk("sink shown", sink_channel, 16'ha5c3);
        chk("precharge off", precharge_on, 16'h0000);
    endtask : t_load_show

    task automatic t_cascade_hold();
        u_ctl.shift_bits(16'hbc0f, 16);
        chk("cascade first bit", {15'h0000, cascade_data_out}, 16'h0001);
        u_ctl.shift_bits(16'h0000, 1);
        chk("cascade next bit", {15'h0000, cascade_data_out}, 16'h0000);
        repeat (12) @(negedge ref_clk);
        chk("latch held", sink_channel, 16'ha5c3);
    endtask : t_cascade_hold

    task automatic t_transparent();
        drive(1'b1, 1'b0, 1'b0);
        u_ctl.shift_bits(16'h0005, 4);
        settle_sink(16'h81e5);
        chk("latch follows", sink_channel, 16'h81e5);
    endtask : t_transparent

    task automatic t_inhibit();
        drive(1'b1, 1'b1, 1'b0);
        repeat (4) @(negedge ref_clk);
        chk("sink forced off", sink_channel, 16'h0000);
        chk("precharge on", precharge_on, 16'hffff);
        drive(1'b1, 1'b0, 1'b0);
        settle_sink(16'h81e5);
        chk("sink restored", sink_channel, 16'h81e5);
        chk("precharge released", precharge_on, 16'h0000);
    endtask : t_inhibit

    task automatic t_fifo_full();
        drive(1'b1, 1'b0, 1'b1);
        u_ctl.shift_bits(16'hffff, 16);
        u_ctl.shift_bits(16'h00ff, 8);
        chk("buffer full", {15'h0000, shift_ready}, 16'h0000);
        drive(1'b1, 1'b0, 1'b0);
        repeat (40) @(negedge ref_clk);
        u_ctl.shift_bits(16'h1234, 16);
        chk("buffer drained", {15'h0000, shift_ready}, 16'h0001);
        settle_sink(16'h1234);
        chk("latch after drain", sink_channel, 16'h1234);
    endtask : t_fifo_full

    ////////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : give_verdict

    initial begin
        arst_n = 1'b0;
        load_gate = 1'b0;
        inhibit = 1'b1;
        drain_hold = 1'b0;
        repeat (4) @(negedge ref_clk);
        arst_n = 1'b1;
        repeat (3) @(negedge ref_clk);
        t_load_show();
        t_cascade_hold();
        t_transparent();
        t_inhibit();
        t_fifo_full();
        give_verdict();
    end

    // The whole run needs about 14 us; some fourteen times that means a hang.
    initial begin
        #200000;
        n_mismatch++;
        give_verdict();
    end

endmodule : tb
